// ===== src/timer_dma_burst_regs.vh
/*
 Register offsets, field positions and reset values of the timer DMA burst window.
 Assumes a 32-bit AXI4-Lite byte address; every register takes one aligned word.
*/
`ifndef TIMER_DMA_BURST_REGS_VH
`define TIMER_DMA_BURST_REGS_VH

`define ADDR_CONTROL_ONE 32'h00000000
`define ADDR_BURST_CONTROL 32'h00000048
`define ADDR_ACCESS_PORT 32'h0000004C
`define ADDR_BURST_OPTION 32'h00000050

`define WORD_BURST_CONTROL 6'h12
`define WORD_ACCESS_PORT 6'h13
`define WORD_BURST_OPTION 6'h14
`define WORD_NONE 6'h3F

`define BANK_DEPTH 6'h12

`define BASE_LSB 0
`define BASE_MSB 4
`define LEN_LSB 8
`define LEN_MSB 12
`define BYTE_MODE_BIT 0

`define CONTROL_WRITE_MASK 16'h1F1F
`define RESET_BURST_CONTROL 16'h0000
`define RESET_ACCESS_PORT 16'h0000

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== src/timer_dma_burst_window.v
/*
 DMA burst access window of a timer, reached as an AXI4-Lite slave.
 Assumes the DMA master and software share clk; one write and one read under way at most.
*/
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "timer_dma_burst_regs.vh"

module timer_dma_burst_window (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [4:0] burstIndex,
  output reg byteMode
);
  reg [15:0] burstControl;
  reg [5:0] awWord;
  reg awHeld;
  reg [15:0] wData;
  reg [1:0] wBe;
  reg wHeld;
  reg [5:0] arWord;
  reg rdPend;

  wire [4:0] burstBaseOffset = burstControl[`BASE_MSB:`BASE_LSB];
  wire [4:0] burstLength = burstControl[`LEN_MSB:`LEN_LSB];

  // word index of an aligned address inside the window, else none
  function [5:0] wordOf;
    input [31:0] a;
    begin
      if (a[31:7] != 25'h0000000 || a[1:0] != 2'h0) begin
        wordOf = `WORD_NONE;
      end else if (a[6:2] > 5'h14) begin
        wordOf = `WORD_NONE;
      end else begin
        wordOf = {1'b0, a[6:2]};
      end
    end
  endfunction

  // register index reached through the port, counted from control one
  function [5:0] targetOf;
    input [4:0] base;
    input [4:0] idx;
    input [1:0] extra;
    begin
      targetOf = {1'b0, base} + {1'b0, idx} + {4'h0, extra};
    end
  endfunction

  // next index; wraps to zero once n plus one registers are covered
  function [4:0] advance;
    input [4:0] idx;
    input [4:0] len;
    input step2;
    reg [5:0] nxt;
    begin
      nxt = {1'b0, idx} + (step2 ? 6'h02 : 6'h01);
      if (nxt > {1'b0, len}) begin
        advance = 5'h00;
      end else begin
        advance = nxt[4:0];
      end
    end
  endfunction

  // true for a word that the target bank holds
  function inBank;
    input [5:0] w;
    begin
      inBank = (w < `BANK_DEPTH);
    end
  endfunction

  wire doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire doRead = rdPend && !doWrite && !s_axi_rvalid;

  wire wPort = (awWord == `WORD_ACCESS_PORT);
  wire rPort = (arWord == `WORD_ACCESS_PORT);
  wire [5:0] tgt0 = targetOf(burstBaseOffset, burstIndex, 2'h0);
  wire [5:0] tgt1 = targetOf(burstBaseOffset, burstIndex, 2'h1);
  wire tgt0Ok = inBank(tgt0);
  wire tgt1Ok = inBank(tgt1) && (burstIndex < burstLength);
  wire wDirect = inBank(awWord);

  wire aEn = doWrite && (wDirect || (wPort && tgt0Ok));
  wire [4:0] aAddr = wPort ? tgt0[4:0] : awWord[4:0];
  // byte mode: upper byte of the item goes to the first register
  wire [15:0] aData = (wPort && byteMode) ? {8'h00, wData[15:8]} : wData;
  wire [1:0] aBe = (wPort && byteMode) ? 2'h3 : wBe;
  wire bEn = doWrite && wPort && byteMode && tgt1Ok;

  wire [5:0] rAddr0 = rPort ? tgt0 : arWord;
  wire [15:0] rData0;
  wire [15:0] rData1;

  timer_target_bank bank (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .aEn(aEn),
    .aAddr(aAddr),
    .aBe(aBe),
    .aData(aData),
    .bEn(bEn),
    .bAddr(tgt1[4:0]),
    .bData(wData[7:0]),
    .rAddr0(rAddr0),
    .rData0(rData0),
    .rAddr1(tgt1),
    .rData1(rData1)
  );

  reg [15:0] next_rdata;
  reg [1:0] next_rresp;

  always @* begin
    next_rresp = `RESP_OKAY;
    next_rdata = 16'h0000;
    case (arWord)
      `WORD_BURST_CONTROL: begin
        next_rdata = burstControl & `CONTROL_WRITE_MASK;
      end
      `WORD_ACCESS_PORT: begin
        if (byteMode) begin
          // pairs two registers back into one item, first one upper
          next_rdata = {rData0[7:0], tgt1Ok ? rData1[7:0] : 8'h00};
        end else begin
          next_rdata = rData0;
        end
      end
      `WORD_BURST_OPTION: begin
        next_rdata = {15'h0000, byteMode};
      end
      `WORD_NONE: begin
        next_rresp = `RESP_SLVERR;
      end
      default: begin
        next_rdata = rData0;
      end
    endcase
  end

  reg [4:0] next_burstIndex;

  // control or option writes restart the burst at the base offset
  always @* begin
    next_burstIndex = burstIndex;
    if (doWrite && (awWord == `WORD_BURST_CONTROL || awWord == `WORD_BURST_OPTION)) begin
      next_burstIndex = 5'h00;
    end else if (doWrite && wPort) begin
      next_burstIndex = advance(burstIndex, burstLength, byteMode);
    end else if (doRead && rPort) begin
      next_burstIndex = advance(burstIndex, burstLength, byteMode);
    end
  end

  // write address channel; ready stays low until the response is taken
  always @(posedge clk) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      awHeld <= 1'b0;
      awWord <= `WORD_NONE;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awWord <= wordOf(s_axi_awaddr);
        awHeld <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  // write data channel; only the low half word and its strobes are kept
  always @(posedge clk) begin
    if (reset) begin
      s_axi_wready <= 1'b1;
      wHeld <= 1'b0;
      wData <= 16'h0000;
      wBe <= 2'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata[15:0];
        wBe <= s_axi_wstrb[1:0];
        wHeld <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write response; addresses outside the window answer with an error
  always @(posedge clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (ce) begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awWord == `WORD_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read address channel; one read under way at a time
  always @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      arWord <= `WORD_NONE;
      rdPend <= 1'b0;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        arWord <= wordOf(s_axi_araddr);
        rdPend <= 1'b1;
        s_axi_arready <= 1'b0;
      end else if (doRead) begin
        rdPend <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // read data; a write in the same cycle goes first so the index moves once
  always @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (doRead) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, next_rdata};
        s_axi_rresp <= next_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // burst control and option
  always @(posedge clk) begin
    if (reset) begin
      burstControl <= `RESET_BURST_CONTROL;
      byteMode <= 1'b0;
    end else if (ce) begin
      if (doWrite && awWord == `WORD_BURST_CONTROL) begin
        // reserved bits never store, so they read back as zero
        burstControl <= {wBe[1] ? wData[15:8] : burstControl[15:8],
                         wBe[0] ? wData[7:0] : burstControl[7:0]}
                        & `CONTROL_WRITE_MASK;
      end
      if (doWrite && awWord == `WORD_BURST_OPTION && wBe[0]) begin
        byteMode <= wData[`BYTE_MODE_BIT];
      end
    end
  end

  // burst index; only the window's own bus traffic moves it
  always @(posedge clk) begin
    if (reset) begin
      burstIndex <= 5'h00;
    end else if (ce) begin
      burstIndex <= next_burstIndex;
    end
  end

endmodule

// ===== src/timer_target_bank.v
/*
 Storage for the timer registers that the burst window redirects to (words 0x00..0x44).
 Assumes one writer per port per cycle; port b writes the low byte and clears the high byte.
*/
`timescale 1ns/1ps
`include "timer_dma_burst_regs.vh"

module timer_target_bank (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire aEn,
  input wire [4:0] aAddr,
  input wire [1:0] aBe,
  input wire [15:0] aData,
  input wire bEn,
  input wire [4:0] bAddr,
  input wire [7:0] bData,
  input wire [5:0] rAddr0,
  output wire [15:0] rData0,
  input wire [5:0] rAddr1,
  output wire [15:0] rData1
);
  reg [15:0] mem [0:17];
  integer i;

  // words past the bank read as zero so a runaway burst cannot alias
  assign rData0 = (rAddr0 < `BANK_DEPTH) ? mem[rAddr0[4:0]] : 16'h0000;
  assign rData1 = (rAddr1 < `BANK_DEPTH) ? mem[rAddr1[4:0]] : 16'h0000;

  always @(posedge clk) begin
    if (reset) begin
      for (i = 0; i < 18; i = i + 1) begin
        mem[i] <= 16'h0000;
      end
    end else if (ce) begin
      if (aEn && aBe[0]) begin
        mem[aAddr][7:0] <= aData[7:0];
      end
      if (aEn && aBe[1]) begin
        mem[aAddr][15:8] <= aData[15:8];
      end
      if (bEn) begin
        mem[bAddr] <= {8'h00, bData};
      end
    end
  end

endmodule

// ===== test/dma_master_model.sv
/* dma controller model: axi4-lite master, one word read or write per call.
 assumes the window's clock; slow delays rready to stall reads. */
`timescale 1ns/1ps
module dma_master_model (
  input wire clk,
  output reg [31:0] s_axi_awaddr,
  output reg s_axi_awvalid,
  input wire s_axi_awready,
  output reg [31:0] s_axi_wdata,
  output reg [3:0] s_axi_wstrb,
  output reg s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output reg s_axi_bready,
  output reg [31:0] s_axi_araddr,
  output reg s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output reg s_axi_rready
);
  integer slow = 0;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task wr(input [31:0] a, input [15:0] d, output [1:0] r);
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d}; // byte pairs travel packed in one item
      s_axi_wstrb <= 4'h3;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      // stale payload is inverted so nothing leans on it
      s_axi_awaddr <= ~a;
      s_axi_wdata <= ~{16'h0000, d};
    end
  endtask
  task rd(input [31:0] a, output [15:0] d, output [1:0] r);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (slow == 0);
      forever begin
        @(posedge clk);
        if (s_axi_rvalid && s_axi_rready) break;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        n = n + 1;
        if (n >= slow) s_axi_rready <= 1'b1;
      end
      d = s_axi_rdata[15:0];
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      s_axi_araddr <= ~a;
    end
  endtask
endmodule

// ===== test/timer_dma_burst_window_sva.sv
/* port checker for the timer dma burst window.
 assumes one clock, synchronous reset, ce held high by the bench. */
`timescale 1ns/1ps
module timer_dma_burst_window_sva (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [4:0] burstIndex,
  input wire byteMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  rst_clear_a: assert property (disable iff (1'b0) reset |=>
    burstIndex == 5'h00 && !byteMode && !s_axi_bvalid && !s_axi_rvalid) else $error("reset");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready && ce |-> ##[1:3] s_axi_rvalid)
    else $error("read late");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half set");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("ar open");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("aw open");
  idx_cause_a: assert property ($changed(burstIndex) |->
    $rose(s_axi_bvalid) || $rose(s_axi_rvalid)) else $error("index moved alone");
  idx_step_a: assert property ($changed(burstIndex) && burstIndex != 5'h00 |->
    burstIndex == $past(burstIndex) + (byteMode ? 5'h02 : 5'h01)) else $error("index step");
  cover property (s_axi_rvalid && s_axi_rready && byteMode);
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (s_axi_bvalid && s_axi_bready && burstIndex == 5'h00);
endmodule

bind timer_dma_burst_window timer_dma_burst_window_sva timer_dma_burst_window_sva_inst (.*);

// ===== test/timer_dma_burst_window_tb.sv
/* self-checking bench for the timer dma burst window.
 assumes the dma model and the window share one 25 MHz clock. */
`timescale 1ns/1ps
`include "timer_dma_burst_regs.vh"
module timer_dma_burst_window_tb;
  localparam [31:0] CTL = `ADDR_BURST_CONTROL;
  localparam [31:0] PRT = `ADDR_ACCESS_PORT;
  localparam [31:0] OPT = `ADDR_BURST_OPTION;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg ce = 1'b1;
  wire [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, byteMode;
  wire [4:0] burstIndex;
  integer errors = 0;
  integer compares = 0;
  integer i;
  reg [15:0] d;
  reg [1:0] r;
  timer_dma_burst_window timer_dma_burst_window_inst (.*);
  dma_master_model dma_master_model_inst (.*);
  always #20 clk = ~clk;
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [31:0] a, input [15:0] v);
    begin
      dma_master_model_inst.wr(a, v, r);
      chk({14'h0000, r}, 16'h0000);
    end
  endtask
  task rd(input [31:0] a, input [15:0] e, input [1:0] er);
    begin
      dma_master_model_inst.rd(a, d, r);
      chk(d, e);
      chk({14'h0000, r}, {14'h0000, er});
    end
  endtask
  task t_reset;
    begin
      rd(CTL, 16'h0000, 2'h0);
      rd(PRT, 16'h0000, 2'h0);
      wr(CTL, 16'hFFFF);
      rd(CTL, 16'h1F1F, 2'h0);
      rd(32'h54, 16'h0000, 2'h2);
      $display("reset test done");
    end
  endtask
  task t_word;
    begin
      wr(CTL, 16'h0202);
      for (i = 0; i < 3; i = i + 1) wr(PRT, 16'hA000 + i[15:0]);
      chk({11'h000, burstIndex}, 16'h0000);
      for (i = 0; i < 3; i = i + 1) rd(32'h8 + 4 * i, 16'hA000 + i[15:0], 2'h0);
      dma_master_model_inst.slow = 3;
      for (i = 0; i < 3; i = i + 1) rd(PRT, 16'hA000 + i[15:0], 2'h0);
      dma_master_model_inst.slow = 0;
      $display("word test done");
    end
  endtask
  task t_max;
    begin
      wr(CTL, 16'h1100);
      for (i = 0; i < 18; i = i + 1) wr(PRT, 16'h5A00 + i[15:0]);
      chk({11'h000, burstIndex}, 16'h0000);
      rd(32'h0, 16'h5A00, 2'h0);
      rd(32'h44, 16'h5A11, 2'h0);
      wr(PRT, 16'h7777);
      rd(32'h0, 16'h7777, 2'h0);
      $display("length test done");
    end
  endtask
  task t_byte;
    begin
      wr(CTL, 16'h0305);
      wr(OPT, 16'h0001);
      chk({15'h0000, byteMode}, 16'h0001);
      wr(PRT, 16'hABCD);
      chk({11'h000, burstIndex}, 16'h0002);
      wr(PRT, 16'h1234);
      chk({11'h000, burstIndex}, 16'h0000);
      rd(32'h14, 16'h00AB, 2'h0);
      rd(32'h18, 16'h00CD, 2'h0);
      rd(32'h20, 16'h0034, 2'h0);
      rd(PRT, 16'hABCD, 2'h0);
      $display("byte test done");
    end
  endtask
  task close_out;
    begin
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_word;
    t_max;
    t_byte;
    close_out;
  end
  // about 200 cycles of traffic; 5000 leaves room for slow reads
  initial begin
    #200000;
    errors = errors + 1;
    close_out;
  end
endmodule
